/* File: gia_unit.sv */
/*
 Guarded integer operation unit: abs, add, add-immediate, rounding
 average, signed byte select, signed clip and the
 instruction-cache invalidate-all with its valid-bit array.
 Assumes the issue logic presents one op per cycle with its slot number,
 operands already read from the register file (register zero reads 0).
*/
`timescale 1ns/1ps
module gia_unit (
   // Clock, reset, enable
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   // Issue
   input wire logic ISSUE_VLD,
   input wire logic [2:0] ISSUE_SLOT,
   input wire logic [7:0] ISSUE_OPC,
   input wire logic [6:0] ISSUE_IMM,
   input wire logic [4:0] ISSUE_DEST,
   input wire logic GUARD_EN,
   input wire logic [31:0] GUARD_REG,
   input wire logic [31:0] SRC_A_REG,
   input wire logic [31:0] SRC_B_REG,
   // Cache line fill and prefetch
   input wire logic FILL_VLD,
   input wire logic [5:0] FILL_IDX,
   input wire logic PREF_REQ,
   // Register file write
   output logic WB_EN,
   output logic [4:0] WB_DEST,
   output logic [31:0] WB_DATA,
   // Cache side effects and slot error
   output logic [63:0] LINE_VALID,
   output logic PREF_PEND,
   output logic FETCH_DISCARD,
   output logic SLOT_ERR
);
   ////////////////////////////////////////////////////////////////////
   wire guard_ok = !GUARD_EN || GUARD_REG[0];
   wire [5:0] slot_bit = 6'h01 << ISSUE_SLOT;
   wire is_abs = ISSUE_OPC == gia_pkg::OPC_IABS;
   wire is_add = ISSUE_OPC == gia_pkg::OPC_IADD;
   wire is_addi = ISSUE_OPC == gia_pkg::OPC_IADDI;
   wire is_avg = ISSUE_OPC == gia_pkg::OPC_IAVG;
   wire is_bsel = ISSUE_OPC == gia_pkg::OPC_BSEL;
   wire is_clip = ISSUE_OPC == gia_pkg::OPC_CLIP;
   wire is_iclr = ISSUE_OPC == gia_pkg::OPC_ICLR;
   wire is_one = is_abs || is_add || is_addi || is_bsel;
   wire is_two = is_avg || is_clip;
   wire slot_ok = is_one ? |(slot_bit & gia_pkg::SLOTS_ALU) :
      is_two ? |(slot_bit & gia_pkg::SLOTS_DSP) :
      is_iclr ? |(slot_bit & gia_pkg::SLOTS_BR) : 1'b0;
   wire go = ISSUE_VLD && slot_ok && guard_ok;
   wire bad_slot = ISSUE_VLD && (is_one || is_two || is_iclr) && !slot_ok;
   ////////////////////////////////////////////////////////////////////
   // Single-cycle results
   wire [31:0] sum_ab = SRC_A_REG + SRC_B_REG;
   wire [31:0] sum_imm = SRC_A_REG + {25'h0, ISSUE_IMM};
   // Zero minus a keeps the most negative value as is
   wire [31:0] abs_v = SRC_A_REG[31] ? 32'h0 - SRC_A_REG : SRC_A_REG;
   // Only the low two index bits decode; others are undefined anyway
   wire [7:0] sel_byte = SRC_A_REG[8 * SRC_B_REG[1:0] +: 8];
   wire [31:0] bsel_v = {{24{sel_byte[7]}}, sel_byte};
   wire [31:0] one_res = is_add ? sum_ab : is_addi ? sum_imm :
      is_abs ? abs_v : bsel_v;
   // Two-cycle results, computed at issue and held one stage
   wire [63:0] avg_sum = {{32{SRC_A_REG[31]}}, SRC_A_REG} +
      {{32{SRC_B_REG[31]}}, SRC_B_REG} + 64'h1;
   wire [31:0] avg_v = avg_sum[32:1];
   wire signed [32:0] lo_b = -$signed({1'b0, SRC_B_REG}) - 33'sh1;
   wire signed [32:0] a_s = $signed({SRC_A_REG[31], SRC_A_REG});
   wire signed [32:0] hi_b = $signed({1'b0, SRC_B_REG});
   wire signed [32:0] clip_s = a_s < lo_b ? lo_b : a_s > hi_b ? hi_b : a_s;
   wire [31:0] two_res = is_avg ? avg_v : clip_s[31:0];
   ////////////////////////////////////////////////////////////////////
   logic st_en_q, st_en_d;
   logic [4:0] st_dest_q;
   logic [31:0] st_data_q;
   logic [1:0] shadow_q, shadow_d;
   wire iclr_go = go && is_iclr;
   assign st_en_d = go && is_two;
   assign shadow_d = iclr_go ? gia_pkg::ICLR_SHADOW - 2'h1 :
      shadow_q != gia_pkg::CNT_RST ? shadow_q - 2'h1 : gia_pkg::CNT_RST;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st_en_q <= 1'b0;
         st_dest_q <= 5'h00;
         st_data_q <= gia_pkg::DATA_RST;
         WB_EN <= 1'b0;
         WB_DEST <= 5'h00;
         WB_DATA <= gia_pkg::DATA_RST;
         shadow_q <= gia_pkg::CNT_RST;
         FETCH_DISCARD <= 1'b0;
         PREF_PEND <= 1'b0;
         SLOT_ERR <= 1'b0;
      end else if (CLK_EN) begin
         st_en_q <= st_en_d;
         st_dest_q <= ISSUE_DEST;
         st_data_q <= two_res;
         // A two-cycle result lands first; a new one-cycle op in the same
         // cycle is a scheduling conflict the issue logic must avoid
         WB_EN <= st_en_q || (go && is_one);
         WB_DEST <= st_en_q ? st_dest_q : ISSUE_DEST;
         WB_DATA <= st_en_q ? st_data_q : one_res;
         shadow_q <= shadow_d;
         FETCH_DISCARD <= iclr_go || shadow_q != gia_pkg::CNT_RST;
         PREF_PEND <= iclr_go ? 1'b0 : (PREF_PEND || PREF_REQ);
         SLOT_ERR <= bad_slot;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Valid bits only; lock and replacement state live elsewhere
   genvar gi;
   generate
      for (gi = 0; gi < gia_pkg::LINE_CNT; gi++) begin : g_line
         always_ff @(posedge SYS_CLK) begin
            if (!RST_N) begin
               LINE_VALID[gi] <= 1'b0;
            end else if (CLK_EN) begin
               if (iclr_go) begin
                  LINE_VALID[gi] <= 1'b0;
               end else if (FILL_VLD && FILL_IDX == 6'(gi)) begin
                  LINE_VALID[gi] <= 1'b1;
               end
            end
         end
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////
   logic [31:0] exp_add_q;
   logic exp_add_v_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         exp_add_q <= gia_pkg::DATA_RST;
         exp_add_v_q <= 1'b0;
      end else if (CLK_EN) begin
         exp_add_q <= SRC_A_REG + SRC_B_REG;
         exp_add_v_q <= go && is_add && !st_en_q;
      end
   end

   chk_add_result: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && exp_add_v_q |-> WB_EN && WB_DATA == exp_add_q)
      else $error("add result wrong");
   chk_guard_blocks: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && ISSUE_VLD && GUARD_EN && !GUARD_REG[0] && !st_en_q |=> !WB_EN)
      else $error("write despite false guard");
   chk_avg_latency: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && is_avg ##1 CLK_EN |=> WB_EN && WB_DATA == $past(avg_v, 2))
      else $error("average late or wrong");
   chk_clip_range: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && is_clip && !SRC_B_REG[31] ##1 CLK_EN |=>
      $signed(WB_DATA) <= $signed($past(SRC_B_REG, 2)))
      else $error("clip above bound");
   chk_iclr_clears: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && iclr_go |=> LINE_VALID == 64'h0)
      else $error("valid bits survive invalidate");
   chk_iclr_prefetch: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && iclr_go |=> !PREF_PEND)
      else $error("prefetch survives invalidate");
   chk_shadow_three: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && iclr_go ##1 (CLK_EN && !iclr_go) [*3] |->
      $past(FETCH_DISCARD, 2) && $past(FETCH_DISCARD) && FETCH_DISCARD ##1 !FETCH_DISCARD)
      else $error("discard window not three");
   chk_false_iclr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && ISSUE_VLD && is_iclr && !guard_ok && !FILL_VLD |=>
      LINE_VALID == $past(LINE_VALID))
      else $error("false guard changed cache");
   chk_abs_wrap: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && is_abs && !st_en_q && SRC_A_REG == 32'h80000000 |=>
      WB_DATA == 32'h80000000)
      else $error("abs of min not wrapped");
   // Slot and operand checks written from the op rules, not from the masks
   chk_avg_slots: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && ISSUE_VLD && is_avg && ISSUE_SLOT != 3'h1 && ISSUE_SLOT != 3'h3 |=>
      SLOT_ERR && !st_en_q)
      else $error("average issued in wrong slot");
   chk_iclr_slots: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && ISSUE_VLD && is_iclr && !FILL_VLD && (ISSUE_SLOT < 3'h2 || ISSUE_SLOT > 3'h4)
      |=> SLOT_ERR && LINE_VALID == $past(LINE_VALID))
      else $error("invalidate issued in wrong slot");
   chk_addi_result: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && is_addi && !st_en_q |=>
      WB_EN && WB_DATA == $past(SRC_A_REG) + {25'h0, $past(ISSUE_IMM)})
      else $error("add-immediate result wrong");
   chk_bsel_sign: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && is_bsel && !st_en_q |=> WB_DATA[31:8] == {24{WB_DATA[7]}})
      else $error("byte select not sign-extended");
   chk_abs_positive: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && is_abs && !st_en_q && SRC_A_REG != 32'h80000000 |=>
      WB_EN && !WB_DATA[31])
      else $error("abs result negative");
   chk_false_pref: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && ISSUE_VLD && is_iclr && !guard_ok && !PREF_REQ && shadow_q == gia_pkg::CNT_RST
      |=> PREF_PEND == $past(PREF_PEND) && !FETCH_DISCARD)
      else $error("false guard disturbed fetch");
   cov_guard_false: cover property (@(posedge SYS_CLK) ISSUE_VLD && !guard_ok);
   cov_avg: cover property (@(posedge SYS_CLK) go && is_avg);
   cov_clip: cover property (@(posedge SYS_CLK) go && is_clip);
   cov_iclr: cover property (@(posedge SYS_CLK) iclr_go);
   cov_slot_err: cover property (@(posedge SYS_CLK) SLOT_ERR);
endmodule

/* File: gia_pkg.sv */
/*
 Shared constants for the guarded integer operation unit: opcodes,
 invalidate shadow length, slot masks, field widths and reset values.
 Assumes a single processor clock and no software-visible registers.
*/
package gia_pkg;
   localparam int DATA_W = 32;
   localparam int OPC_W = 8;
   localparam int IMM_W = 7;
   localparam int SLOT_W = 3;
   localparam int LINE_CNT = 64;
   // Opcodes as issued by the decode stage
   localparam logic [7:0] OPC_IABS = 8'h2c;
   localparam logic [7:0] OPC_IADD = 8'h0c;
   localparam logic [7:0] OPC_IADDI = 8'h05;
   localparam logic [7:0] OPC_IAVG = 8'h19;
   localparam logic [7:0] OPC_BSEL = 8'h38;
   localparam logic [7:0] OPC_CLIP = 8'h4a;
   localparam logic [7:0] OPC_ICLR = 8'hb8;
   // Slot masks, bit n set when slot n may issue the op
   localparam logic [5:0] SLOTS_ALU = 6'h3e;
   localparam logic [5:0] SLOTS_DSP = 6'h0a;
   localparam logic [5:0] SLOTS_BR = 6'h1c;
   // Instructions discarded behind an invalidate-all, issuing one not included
   localparam logic [1:0] ICLR_SHADOW = 2'h3;
   localparam logic [31:0] DATA_RST = 32'h0;
   localparam logic [1:0] CNT_RST = 2'h0;
endpackage

/* File: gia_rf_model.sv */
/* Register file model standing behind the unit's write port.
   Assumes single-cycle write strobes sampled on the rising edge. */
`timescale 1ns/1ps
module gia_rf_model (
   // Clock
   input wire logic clk,
   // Write port from the unit
   input wire logic wb_en,
   input wire logic [4:0] wb_dest,
   input wire logic [31:0] wb_data,
   // Bench read port
   input wire logic [4:0] rd_idx,
   output logic [31:0] rd_data
);
   logic [31:0] rf_q [32] = '{default: 32'h0};
   always @(posedge clk) begin
      if (wb_en) rf_q[wb_dest] <= wb_data;
   end
   // Register zero is hard-wired and always reads as 0
   assign rd_data = (rd_idx == 5'h0) ? 32'h0 : rf_q[rd_idx];
endmodule

/* File: tb_guarded_integer_alu_ops.sv */
/* Self-checking bench for the guarded integer operation unit.
   Assumes the register file model beside it; inputs move on falling edges. */
`timescale 1ns/1ps
module tb_guarded_integer_alu_ops;
   logic clk = 0, rst_n = 0, vld = 0, gen = 0, fill = 0, pref = 0, cen = 1;
   logic [2:0] slot = 3'h1;
   logic [7:0] opc = 8'h0;
   logic [6:0] imm = 7'h0;
   logic [4:0] dst = 5'h1, rd = 5'h0, wd;
   logic [5:0] fidx = 6'h0;
   logic [31:0] gval = 32'h0, sa = 32'h0, sb = 32'h0, seed, rdd, wdat;
   logic [31:0] sh [32] = '{default: 32'h0};
   logic [63:0] lv;
   logic we, pp, fd, se;
   logic [7:0] tbl [6] = '{8'h2c, 8'h0c, 8'h05, 8'h19, 8'h38, 8'h4a};
   int err_count = 0, n_checks = 0;
   gia_unit gia_unit_i (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(cen), .ISSUE_VLD(vld),
      .ISSUE_SLOT(slot), .ISSUE_OPC(opc), .ISSUE_IMM(imm), .ISSUE_DEST(dst), .GUARD_EN(gen),
      .GUARD_REG(gval), .SRC_A_REG(sa), .SRC_B_REG(sb), .FILL_VLD(fill), .FILL_IDX(fidx),
      .PREF_REQ(pref), .WB_EN(we), .WB_DEST(wd), .WB_DATA(wdat), .LINE_VALID(lv),
      .PREF_PEND(pp), .FETCH_DISCARD(fd), .SLOT_ERR(se));
   gia_rf_model gia_rf_model_i (.clk(clk), .wb_en(we), .wb_dest(wd), .wb_data(wdat),
      .rd_idx(rd), .rd_data(rdd));
   initial forever #12.5 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////
   function logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function logic [31:0] expv(input logic [7:0] o, input logic [31:0] a, b);
      logic [63:0] s;
      s = {{32{a[31]}}, a} + {{32{b[31]}}, b} + 64'h1;
      case (o)
         8'h2c: return a[31] ? -a : a;
         8'h0c: return a + b;
         8'h05: return a + {25'h0, imm};
         8'h19: return s[32:1];
         8'h38: return {{24{a[8 * b[1:0] + 7]}}, a[8 * b[1:0] +: 8]};
         default: return $signed(a) > $signed(b) ? b : $signed(a) < $signed(~b) ? ~b : a;
      endcase
   endfunction
   function logic slot_legal(input logic [7:0] o, input logic [2:0] s);
      case (o)
         8'h19, 8'h4a: return s == 3'h1 || s == 3'h3;
         8'hb8: return s >= 3'h2 && s <= 3'h4;
         default: return s >= 3'h1 && s <= 3'h5;
      endcase
   endfunction
   task chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task op(input logic [7:0] o, input logic [2:0] s, input logic gb, ok,
      input logic [31:0] a, b);
      logic [31:0] e;
      logic wr;
      seed = nxt(seed);
      dst = 5'h1 + 5'(seed[7:0] % 31);
      imm = seed[14:8];
      e = expv(o, a, b);
      opc = o;
      slot = s;
      // Guard absent in about half the ops, so only legality gates the write
      gen = seed[15];
      gval = {seed[31:1], gb};
      wr = (gb || !seed[15]) && ok;
      sa = a;
      sb = b;
      vld = 1;
      @(negedge clk);
      vld = 0;
      chk(se, !ok);
      if (o == 8'h19 || o == 8'h4a) @(negedge clk);
      // Dest and data lines move every cycle; only the strobe matters when idle
      if (wr) chk({we, wd, wdat}, {1'b1, dst, e});
      else chk(we, 1'b0);
      if (wr) sh[dst] = e;
      rd = dst;
      @(negedge clk);
      chk(rdd, sh[dst]);
   endtask
   task iclr(input logic gb, input logic [2:0] s);
      logic [63:0] v;
      logic hit;
      v = 64'h0;
      hit = gb && slot_legal(8'hb8, s);
      for (int i = 0; i < 64; i += 9) begin
         fill = 1;
         fidx = 6'(i);
         v[i] = 1'b1;
         @(negedge clk);
      end
      fill = 0;
      pref = 1;
      @(negedge clk);
      pref = 0;
      opc = 8'hb8;
      slot = s;
      gen = 1;
      gval = {31'h0, gb};
      vld = 1;
      @(negedge clk);
      vld = 0;
      chk(se, !slot_legal(8'hb8, s));
      chk(lv, hit ? 64'h0 : v);
      chk(pp, !hit);
      repeat (3) begin
         chk(fd, hit);
         @(negedge clk);
      end
      chk(fd, 0);
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      logic [2:0] rs;
      seed = 32'h32d3;
      repeat (3) @(negedge clk);
      rst_n = 1;
      op(8'h2c, 3'h1, 1, 1, 32'h80000000, 32'h0);
      op(8'h0c, 3'h5, 1, 1, 32'h0, 32'h12345678);
      op(8'h19, 3'h2, 1, 0, 32'h10, 32'h20);
      op(8'h4a, 3'h3, 1, 1, 32'h80000000, 32'h3fffff);
      // Frozen unit must ignore an add that stands on the issue port
      cen = 0;
      opc = 8'h0c;
      slot = 3'h1;
      gen = 0;
      vld = 1;
      repeat (2) @(negedge clk);
      chk({we, se}, 2'h0);
      vld = 0;
      cen = 1;
      @(negedge clk);
      chk(we, 1'b0);
      $display("test freeze done");
      for (int i = 0; i < 80; i++) begin
         seed = nxt(seed);
         sa = seed;
         seed = nxt(seed);
         opc = tbl[seed[31:29] % 6];
         sb = (opc == 8'h38) ? {30'h0, seed[1:0]} : (opc == 8'h4a) ? seed >> 1 : seed;
         rs = seed[7] ? seed[4:2] : (opc == 8'h19 || opc == 8'h4a) ? {1'b0, seed[2], 1'b1} :
            3'h1 + 3'(seed[4:2] % 5);
         op(opc, rs, seed[5] | seed[6], slot_legal(opc, rs), sa, sb);
      end
      $display("test ops done");
      iclr(0, 3'h2);
      iclr(1, 3'h5);
      iclr(1, 3'h4);
      $display("test iclr done");
      summarize();
   end
endmodule
